//--- logic/cdc_cable_diag.sv
// cable diagnostics control: reflectometry sequencing and matched-length result
// assumes pins from the analog side are asynchronous and software keeps to its setup
`timescale 1ns/1ns
`default_nettype none
module cdc_cable_diag
	import cdc_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC
)(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// control bits from software
	input wire logic i_tdr_enable,
	input wire logic i_auto_mdix_en,
	input wire logic i_pair_select_override,
	input wire logic i_mdix_state,
	// link status and matched-length estimate
	input wire logic i_link_up,
	input wire logic i_link_100,
	input wire logic [CODE_W-1:0] i_cable_length_code,
	// reflection detector pin
	input wire logic i_reflect_det,
	// line side
	output logic [1:0] o_pulse,
	output logic o_link_drop,
	// status to software
	output logic o_tdr_busy,
	output logic o_tdr_done,
	output logic o_tdr_valid,
	output logic [LEN_W-1:0] o_channel_length,
	output logic o_code_valid,
	output logic [CODE_W-1:0] o_cable_length_code
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic refl_s1_r;
	logic refl_s2_r;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			refl_s1_r <= 1'b0;
			refl_s2_r <= 1'b0;
		end
		else
		begin
			refl_s1_r <= i_reflect_det;
			refl_s2_r <= refl_s1_r;
		end
	end

	// ----------------------------------------
	// reflectometry sequencer
	// ----------------------------------------
	localparam int CNT_W = $clog2(WINDOW_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_WIN = CNT_W'(WINDOW_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_PULSE = CNT_W'(PULSE_CYC - 1);
	// coarse length unit: listen count shifted right by CNT_W - LEN_W bits when CNT_W > LEN_W, else one cycle
	localparam int BIN_SH = (CNT_W > LEN_W) ? CNT_W - LEN_W : 0;

	cdc_state_e state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [LEN_W-1:0] len_r, len_nxt;
	logic valid_r, valid_nxt;
	logic done_r, done_nxt;
	logic sel_rx_pair;
	cdc_pulse_s pulse_r, pulse_nxt;

	// manual selection only matters with crossover off; else use resolved state
	always_comb
	begin
		if (!i_auto_mdix_en)
			sel_rx_pair = i_pair_select_override;
		else
			sel_rx_pair = i_mdix_state;
	end

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		valid_nxt = valid_r;
		done_nxt = done_r;
		pulse_nxt = '0;
		unique case (state_r)
			CDC_IDLE:
			begin
				if (i_tdr_enable)
				begin
					state_nxt = CDC_PULSE;
					cnt_nxt = '0;
					done_nxt = 1'b0;
					valid_nxt = 1'b0;
					len_nxt = LEN_RST;
				end
			end
			CDC_PULSE:
			begin
				pulse_nxt.drive_tx_pair = ~sel_rx_pair;
				pulse_nxt.drive_rx_pair = sel_rx_pair;
				if (cnt_r == CNT_PULSE)
				begin
					state_nxt = CDC_LISTEN;
					cnt_nxt = '0;
					// pulse stays up through this last count, so it lasts PULSE_CYC cycles
				end
				else
					cnt_nxt = cnt_r + 1'b1;
			end
			CDC_LISTEN:
			begin
				// delay counted from end of pulse to first reflection
				if (refl_s2_r)
				begin
					len_nxt = LEN_W'(cnt_r >> BIN_SH);
					valid_nxt = 1'b1;
					state_nxt = CDC_DONE;
				end
				else if (cnt_r == CNT_WIN)
				begin
					// no echo: matched cable, length stays flagged invalid
					valid_nxt = 1'b0;
					state_nxt = CDC_DONE;
				end
				else
					cnt_nxt = cnt_r + 1'b1;
			end
			CDC_DONE:
			begin
				done_nxt = 1'b1;
				// result holds until software clears the enable and rearms
				if (!i_tdr_enable)
					state_nxt = CDC_IDLE;
			end
		endcase
		if (!i_tdr_enable && state_r != CDC_DONE)
		begin
			state_nxt = CDC_IDLE;
			pulse_nxt = '0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state_r <= CDC_IDLE;
			cnt_r <= '0;
			len_r <= LEN_RST;
			valid_r <= 1'b0;
			done_r <= 1'b0;
			pulse_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			len_r <= len_nxt;
			valid_r <= valid_nxt;
			done_r <= done_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// ----------------------------------------
	// output registers
	// ----------------------------------------
	logic drop_nxt;
	logic code_valid_nxt;
	logic busy_nxt;
	logic tdr_valid_nxt;
	logic [CODE_W-1:0] code_nxt;

	always_comb
	begin
		// link held down for the whole test, from enable onward
		drop_nxt = i_tdr_enable && (state_nxt != CDC_IDLE || state_r == CDC_IDLE);
		code_valid_nxt = i_link_up && i_link_100;
		code_nxt = code_valid_nxt ? i_cable_length_code : CODE_RST;
		// status is registered so software never sees a decode glitch
		busy_nxt = (state_nxt == CDC_PULSE) || (state_nxt == CDC_LISTEN);
		tdr_valid_nxt = valid_nxt && done_nxt;
	end

	logic drop_r;
	logic cv_r;
	logic busy_r;
	logic tdr_valid_r;
	logic [CODE_W-1:0] code_r;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			drop_r <= 1'b0;
			cv_r <= 1'b0;
			busy_r <= 1'b0;
			tdr_valid_r <= 1'b0;
			code_r <= CODE_RST;
		end
		else
		begin
			drop_r <= drop_nxt;
			cv_r <= code_valid_nxt;
			busy_r <= busy_nxt;
			tdr_valid_r <= tdr_valid_nxt;
			code_r <= code_nxt;
		end
	end

	assign o_pulse = {pulse_r.drive_rx_pair, pulse_r.drive_tx_pair};
	assign o_link_drop = drop_r;
	assign o_tdr_busy = busy_r;
	assign o_tdr_done = done_r;
	assign o_tdr_valid = tdr_valid_r;
	assign o_channel_length = len_r;
	assign o_code_valid = cv_r;
	assign o_cable_length_code = code_r;
endmodule : cdc_cable_diag
`default_nettype wire

//--- logic/cdc_pkg.sv
// cable diagnostics control package: field widths, timing counts, state codes
// assumes nothing beyond a systemverilog-2012 compiler
`default_nettype none
package cdc_pkg;
	localparam int LEN_W = 8;
	localparam int CODE_W = 4;
	// pulse width and reflection listening window, in ns
	localparam int PULSE_NS = 8;
	localparam int CLK_NS = 4;
	localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WINDOW_NS = 4000;
	localparam int WINDOW_CYC = WINDOW_NS / CLK_NS;
	localparam logic [LEN_W-1:0] LEN_RST = 8'h00;
	localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
	localparam logic [CODE_W-1:0] CODE_MIN_VALID = 4'h4;

	typedef enum logic [1:0] {
		CDC_IDLE = 2'b00,
		CDC_PULSE = 2'b01,
		CDC_LISTEN = 2'b10,
		CDC_DONE = 2'b11
	} cdc_state_e;

	// line-side drive request toward the analog front end
	typedef struct packed {
		logic drive_tx_pair;
		logic drive_rx_pair;
	} cdc_pulse_s;
endpackage : cdc_pkg
`default_nettype wire

//--- dv/cdc_properties.sv
// checker: port properties of the cable diagnostics block
// assumes it is bound onto cdc_cable_diag and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module cdc_props
	import cdc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_tdr_enable,
	input wire logic i_auto_mdix_en,
	input wire logic i_pair_select_override,
	input wire logic i_mdix_state,
	input wire logic i_link_up,
	input wire logic i_link_100,
	input wire logic [1:0] o_pulse,
	input wire logic o_link_drop,
	input wire logic o_tdr_busy,
	input wire logic o_tdr_done,
	input wire logic o_tdr_valid,
	input wire logic [LEN_W-1:0] o_channel_length,
	input wire logic o_code_valid,
	input wire logic [CODE_W-1:0] o_cable_length_code
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_held;
		o_tdr_done ##1 o_tdr_done;
	endsequence
	a_pair_manual: assert property (o_pulse != 2'h0 && !i_auto_mdix_en |->
		o_pulse == {i_pair_select_override, !i_pair_select_override}) else $error("manual pair wrong");
	a_pair_onehot: assert property (o_pulse != 2'h0 |-> $onehot(o_pulse)) else $error("both pairs pulsed");
	a_abort_idle: assert property (!i_tdr_enable |=> !o_tdr_busy && !o_link_drop) else $error("test kept after enable low");
	a_length_hold: assert property (s_held |-> $stable(o_channel_length)) else $error("length moved");
	a_link_drop: assert property (o_tdr_busy |-> o_link_drop) else $error("link kept during test");
	a_code_gate: assert property (!(i_link_up && i_link_100) |=>
		!o_code_valid && o_cable_length_code == 4'h0) else $error("code shown without link");
	a_valid_done: assert property (o_tdr_valid |-> o_tdr_done) else $error("valid without done");
endmodule : cdc_props
bind cdc_cable_diag cdc_props chk_u (.*);
`default_nettype wire

//--- dv/cdc_cable_model.sv
// cable model: answers each pulse with one reflection when faulted
// assumes the pulse bus is registered on i_clk
`timescale 1ns/1ns
`default_nettype none
module cdc_cable_model #(
	parameter int ECHO_CYC = 6
) (
	input wire logic i_clk,
	input wire logic [1:0] i_pulse,
	input wire logic i_fault,
	output logic o_det
);
	int cnt_r = -1;
	initial o_det = 1'h0;
	always @(posedge i_clk)
	begin
		o_det <= 1'h0;
		if (i_pulse != 2'h0)
			cnt_r <= ECHO_CYC;
		else if (cnt_r > 0)
			cnt_r <= cnt_r - 1;
		else if (cnt_r == 0)
		begin
			// a matched cable never echoes
			o_det <= i_fault;
			cnt_r <= -1;
		end
	end
endmodule : cdc_cable_model
`default_nettype wire

//--- dv/cdc_cable_diag_tb_top.sv
// bench: reflectometry runs on each pair, then the length code gate
// assumes the cable model reflects every pulse when faulted
`timescale 1ns/1ns
`default_nettype none
module cdc_cable_diag_tb_top
	import cdc_pkg::*;
;
	logic i_clk = 1'h0, i_rst_n = 1'h0, i_tdr_enable = 1'h0, i_auto_mdix_en = 1'h0;
	logic i_pair_select_override = 1'h0, i_mdix_state = 1'h0, i_link_up = 1'h0, i_link_100 = 1'h0;
	logic [CODE_W-1:0] i_cable_length_code = 4'h0;
	logic i_reflect_det, fault = 1'h0, o_link_drop, o_tdr_busy, o_tdr_done, o_tdr_valid, o_code_valid;
	logic [1:0] o_pulse, seen;
	logic [LEN_W-1:0] o_channel_length;
	logic [CODE_W-1:0] o_cable_length_code;
	logic bad_drop;
	int bad_count = 0, compares = 0;
	// listen count covers the pulse tail, the echo delay and the two sync stages
	localparam int ECHO_CYC = 6;
	localparam logic [LEN_W-1:0] EXP_LEN = LEN_W'(ECHO_CYC + PULSE_CYC + 2);
	initial forever #2 i_clk = ~i_clk;
	cdc_cable_diag #(.WINDOW_CYCLES(64)) dut_u (.*);
	cdc_cable_model #(.ECHO_CYC(ECHO_CYC)) cab_u (.i_clk(i_clk), .i_pulse(o_pulse), .i_fault(fault), .o_det(i_reflect_det));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// one test with the link up, so the forced drop is visible
	task automatic run(input logic a, input logic o, input logic m, input logic f);
		seen = 2'h0;
		bad_drop = 1'h0;
		i_auto_mdix_en <= a;
		i_link_100 <= 1'h1;
		i_pair_select_override <= o;
		i_mdix_state <= m;
		fault <= f;
		i_link_up <= 1'h1;
		i_tdr_enable <= 1'h1;
		repeat (2) @(posedge i_clk);
		for (int i = 0; i < 200 && !o_tdr_done; i++)
		begin
			@(posedge i_clk);
			seen |= o_pulse;
			bad_drop |= o_tdr_busy & ~o_link_drop;
		end
		chk("done", 8'h01, {7'h0, o_tdr_done});
		chk("valid", {7'h0, f}, {7'h0, o_tdr_valid});
		chk("pair", {6'h0, a ? {m, ~m} : {o, ~o}}, {6'h0, seen});
		chk("drop", 8'h00, {7'h0, bad_drop});
		if (f)
			chk("length", EXP_LEN, o_channel_length);
		i_tdr_enable <= 1'h0;
		i_link_up <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk("drop_end", 8'h00, {7'h0, o_link_drop});
	endtask : run
	task automatic end_of_test;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(posedge i_clk);
		run(1'h0, 1'h0, 1'h1, 1'h1);
		run(1'h0, 1'h1, 1'h0, 1'h1);
		run(1'h0, 1'h0, 1'h0, 1'h1);
		run(1'h0, 1'h1, 1'h1, 1'h1);
		run(1'h0, 1'h1, 1'h0, 1'h0);
		// enable dropped mid-test: back to idle with no result
		i_tdr_enable <= 1'h1;
		repeat (3) @(posedge i_clk);
		chk("abort_busy", 8'h01, {7'h0, o_tdr_busy});
		chk("abort_drop", 8'h01, {7'h0, o_link_drop});
		i_tdr_enable <= 1'h0;
		repeat (2) @(posedge i_clk);
		chk("abort_idle", 8'h00, {7'h0, o_tdr_busy});
		chk("abort_drop_end", 8'h00, {7'h0, o_link_drop});
		chk("abort_done", 8'h00, {7'h0, o_tdr_done});
		i_link_up <= 1'h1;
		i_link_100 <= 1'h1;
		i_cable_length_code <= 4'hf;
		repeat (3) @(posedge i_clk);
		chk("code", 8'h0f, {4'h0, o_cable_length_code});
		chk("code_valid", 8'h01, {7'h0, o_code_valid});
		i_link_100 <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk("code", 8'h00, {4'h0, o_cable_length_code});
		chk("code_valid", 8'h00, {7'h0, o_code_valid});
		end_of_test();
	end
	initial
	begin
		repeat (3000) @(posedge i_clk);
		bad_count++;
		end_of_test();
	end
endmodule : cdc_cable_diag_tb_top
`default_nettype wire
